// ===== hdl/scs_pkg.sv
package scs_pkg;
  // register addresses on the plain port
  localparam logic [1:0] ADDR_OSC_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CLK_DIVISOR = 2'h1;
  localparam logic [1:0] ADDR_PLL_FEEDBACK = 2'h2;

  // oscillator control field positions
  localparam int CUR_SRC_LSB   = 12;
  localparam int NEW_SRC_LSB   = 8;
  localparam int SRC_LOCK_BIT  = 7;
  localparam int PIN_LOCK_BIT  = 6;
  localparam int PLL_LOCK_BIT  = 5;
  localparam int CLK_FAIL_BIT  = 3;
  localparam int SEC_OSC_BIT   = 1;
  localparam int SWITCH_BIT    = 0;

  // clock divisor field positions
  localparam int RECOVER_BIT   = 15;
  localparam int REDUCE_LSB    = 12;
  localparam int REDUCE_EN_BIT = 11;
  localparam int FRC_POST_LSB  = 8;
  localparam int PLL_POST_LSB  = 6;
  localparam int PLL_PRE_LSB   = 0;

  // source selection codes
  localparam logic [2:0] SRC_FRC        = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL    = 3'h1;
  localparam logic [2:0] SRC_PRIMARY    = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL    = 3'h3;
  localparam logic [2:0] SRC_SECONDARY  = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC       = 3'h5;
  localparam logic [2:0] SRC_FRC_DIV16  = 3'h6;
  localparam logic [2:0] SRC_FRC_DIVN   = 3'h7;

  // primary mode codes
  localparam logic [1:0] PRI_EXTERNAL   = 2'h0;
  localparam logic [1:0] PRI_CRYSTAL    = 2'h1;
  localparam logic [1:0] PRI_HS_CRYSTAL = 2'h2;

  // switch monitor configuration: switching on, monitor off
  localparam logic [1:0] FCK_SWITCH_ONLY = 2'h1;

  // reset values
  localparam logic [2:0] RST_REDUCE   = 3'h3;
  localparam logic [1:0] RST_PLL_POST = 2'h1;
  localparam logic [4:0] RST_PLL_PRE  = 5'h00;
  localparam logic [2:0] RST_FRC_POST = 3'h0;
  localparam logic [8:0] RST_PLL_FB   = 9'h030;

  localparam logic [8:0] FACTOR_OFFSET = 9'h002;
  localparam logic [3:0] SWITCH_WAIT   = 4'ha;
  localparam logic [1:0] POST_RESERVED = 2'h2;

  typedef struct packed {
    logic        recoverOnInt;
    logic [2:0]  reduceField;
    logic        reduceEnable;
    logic [2:0]  frcPostField;
    logic [1:0]  pllPostField;
    logic [4:0]  pllPreField;
  } scs_divisor_type;

  typedef struct packed {
    logic [5:0]  prescale;   // 2..33, needs six bits
    logic [9:0]  multiplier; // 2..513
    logic [3:0]  postscale;  // 2,4,8
  } scs_pll_cfg_type;
endpackage

// ===== hdl/scs_clock_mux.sv
// glitch-free two-stage handover between old and new source selection
module scs_clock_mux (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       reset_n,    // async reset, active low
  input  wire logic [7:0] srcClocks,  // one clock per selection code
  input  wire logic [2:0] selCode,    // requested selection
  input  wire logic [2:0] initCode,   // selection after reset
  output logic            clockOut    // muxed clock
);
  logic [2:0] activeSel_ff;
  logic [7:0] gate_ff;
  logic       loaded_ff;

  // one gate at a time, and a gate moves only while its source is low, so no
  // pulse is shortened; sources are sampled on sys_clk, so sources must be slower
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      activeSel_ff <= 3'h0;
      gate_ff      <= 8'h00;
      loaded_ff    <= 1'b0;
    end else if (!loaded_ff) begin
      activeSel_ff <= initCode;
      loaded_ff    <= 1'b1;
    end else if (gate_ff == 8'h00) begin
      if (!srcClocks[activeSel_ff]) begin
        gate_ff <= 8'h01 << activeSel_ff; // open while new source is low
      end
    end else if (selCode != activeSel_ff && !srcClocks[activeSel_ff]) begin
      gate_ff      <= 8'h00; // close old gate while it is low
      activeSel_ff <= selCode;
    end
  end

  assign clockOut = |(srcClocks & gate_ff);
endmodule

// ===== hdl/scs_clock_control.sv
// Notes on behaviour
// - instruction clock is source divided by two
// - prescale factor is field plus two
// - multiplier is feedback field plus two
// - postscaler 2, 4, reserved, 8
// - output equals input times M over N1N2
// - three-bit selection code maps eight sources
// - primary mode picks external, crystal, high-speed
// - unprogrammed part starts in programmable-divide RC
// - new-source field loads from configuration, writable
// - source lock bit blocks switching when enabled
// - pin select lock rejects pin-select writes
// - PLL lock status reads locked or timer done; here pllLocked only, while a PLL source is current or new
// - clock fail flag set by monitor, software clears
// - secondary oscillator enable follows its bit
// - switch request set by software, cleared when done
// - recover on interrupt clears reduced speed
// - reduction field divides by two to power
// - reduced speed off forces ratio one to one
// - fast RC postscaler 1..64 then 256
// - current source field reports active source
// - switch waits ready then ten new clocks
//
// Design decisions made here: the register addresses and the plain strobed port.
module scs_clock_control
  import scs_pkg::*;
(
  input  wire logic                   sys_clk,        // system clock, 250 MHz
  input  wire logic                   reset_n,        // async reset, active low
  input  wire logic [1:0]             regAddr,        // register address
  input  wire logic [15:0]            regWdata,       // write data
  input  wire logic                   regWrite,       // write strobe
  input  wire logic                   regRead,        // read strobe
  output logic [15:0]                 regRdata,       // read data, cycle after strobe
  input  wire logic [2:0]             initialSourceConfig, // strap: initial source
  input  wire logic [1:0]             primaryModeConfig,   // strap: primary mode
  input  wire logic [1:0]             switchMonitorConfig, // strap: switch/monitor
  input  wire logic                   unlockHigh,     // unlock done for high byte
  input  wire logic                   unlockLow,      // unlock done for low byte
  input  wire logic [7:0]             srcClocks,      // raw clocks per selection code
  input  wire logic [7:0]             srcReady,       // source ready per code
  input  wire logic                   pllLocked,      // analogue PLL lock
  input  wire logic                   clockFailDetect,// monitor fail pulse
  input  wire logic                   interruptEvent, // any interrupt, one-cycle pulse
  input  wire logic                   newSrcClock,    // raw clock of new source, edges found here
  input  wire logic                   pinSelectWrite, // attempted pin-select write
  output logic                        pinSelectWriteOk, // pin-select write allowed
  output logic                        secondaryOscOn, // secondary oscillator enable
  output logic [2:0]                  activeSource,   // current source code
  output logic [1:0]                  primaryMode,    // primary drive mode
  output logic                        usesPll,        // active source runs via PLL
  output scs_pll_cfg_type             pllCfg,         // PLL factors
  output logic [8:0]                  frcDivide,      // fast RC postscale factor
  output logic [7:0]                  dozeDivide,     // processor clock ratio
  output logic                        instrClkDiv2,   // instruction clock divide marker
  output logic                        systemClock     // glitch-free selected clock
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {SW_IDLE, SW_WAIT_READY, SW_COUNT} scs_sw_state_type;

  scs_sw_state_type swState_ff;
  scs_divisor_type  div_ff;
  logic [8:0]       pllFb_ff;
  logic [2:0]       curSrc_ff, newSrc_ff;
  logic             srcLock_ff, pinLock_ff, clkFail_ff, secOsc_ff, switchReq_ff;
  logic             strapTaken_ff, primed_ff, pllLockStat_ff, newSrcClk_ff;
  logic [3:0]       waitCnt_ff;
  logic [15:0]      rdata_ff;
  logic             switchAllowed, wrCtrlHi, wrCtrlLo, wrDiv, wrFb, newEdge;

  function automatic logic [7:0] pow2(input logic [2:0] code);
    pow2 = 8'h01 << code;
  endfunction

  function automatic logic src_has_pll(input logic [2:0] code);
    src_has_pll = (code == SRC_FRC_PLL) || (code == SRC_PRI_PLL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // unlock qualifies each byte of the control register
  assign wrCtrlHi = regWrite && regAddr == ADDR_OSC_CONTROL && unlockHigh;
  assign wrCtrlLo = regWrite && regAddr == ADDR_OSC_CONTROL && unlockLow;
  assign wrDiv    = regWrite && regAddr == ADDR_CLK_DIVISOR;
  assign wrFb     = regWrite && regAddr == ADDR_PLL_FEEDBACK;
  // switching needs enable strap and, in switch-only mode, no source lock
  assign switchAllowed = !switchMonitorConfig[1] &&
                         !(switchMonitorConfig == FCK_SWITCH_ONLY && srcLock_ff);
  assign newEdge = newSrcClock && !newSrcClk_ff;

  ////////////////////////////////////////////////////////////////////////////
  // the initial-source strap is caught once after reset release, not by the reset itself
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapTaken_ff <= 1'b0;
      primed_ff     <= 1'b0;
    end else begin
      strapTaken_ff <= 1'b1;
      primed_ff     <= strapTaken_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      newSrc_ff <= SRC_FRC_DIVN; // unprogrammed default
    end else if (!strapTaken_ff) begin
      newSrc_ff <= initialSourceConfig;
    end else if (wrCtrlHi) begin
      newSrc_ff <= regWdata[NEW_SRC_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      srcLock_ff <= 1'b0;
      pinLock_ff <= 1'b0;
      secOsc_ff  <= 1'b0;
    end else if (wrCtrlLo) begin
      // clearing the lock lets software switch sources again
      srcLock_ff <= regWdata[SRC_LOCK_BIT];
      pinLock_ff <= regWdata[PIN_LOCK_BIT];
      secOsc_ff  <= regWdata[SEC_OSC_BIT];
    end
  end

  // monitor set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkFail_ff <= 1'b0;
    end else if (clockFailDetect) begin
      clkFail_ff <= 1'b1;
    end else if (swState_ff == SW_IDLE && switchReq_ff && newSrc_ff != curSrc_ff) begin
      clkFail_ff <= 1'b0;
    end else if (wrCtrlLo && !regWdata[CLK_FAIL_BIT]) begin
      clkFail_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pllLockStat_ff <= 1'b0;
    end else if (swState_ff == SW_IDLE && switchReq_ff && newSrc_ff != curSrc_ff) begin
      pllLockStat_ff <= 1'b0;
    end else begin
      pllLockStat_ff <= pllLocked && (src_has_pll(curSrc_ff) || src_has_pll(newSrc_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      newSrcClk_ff <= 1'b0;
    end else begin
      newSrcClk_ff <= newSrcClock;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      swState_ff   <= SW_IDLE;
      switchReq_ff <= 1'b0;
      curSrc_ff    <= SRC_FRC_DIVN;
      waitCnt_ff   <= 4'h0;
    end else if (!primed_ff) begin
      curSrc_ff <= initialSourceConfig;
    end else begin
      case (swState_ff)
        SW_IDLE: begin
          if (switchReq_ff) begin
            if (newSrc_ff == curSrc_ff) begin
              switchReq_ff <= 1'b0; // redundant request aborts
            end else begin
              swState_ff <= SW_WAIT_READY;
            end
          end else if (wrCtrlLo && regWdata[SWITCH_BIT] && switchAllowed) begin
            switchReq_ff <= 1'b1;
          end
        end
        SW_WAIT_READY: begin
          waitCnt_ff <= 4'h0;
          if (srcReady[newSrc_ff] && (!src_has_pll(newSrc_ff) || pllLocked)) begin
            swState_ff <= SW_COUNT;
          end
        end
        SW_COUNT: begin
          if (newEdge) begin
            if (waitCnt_ff == SWITCH_WAIT - 4'h1) begin
              curSrc_ff    <= newSrc_ff;
              switchReq_ff <= 1'b0;
              swState_ff   <= SW_IDLE;
            end else begin
              waitCnt_ff <= waitCnt_ff + 4'h1;
            end
          end
        end
        default: swState_ff <= SW_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divisor and feedback registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= '{recoverOnInt: 1'b0, reduceField: RST_REDUCE, reduceEnable: 1'b0,
                  frcPostField: RST_FRC_POST, pllPostField: RST_PLL_POST,
                  pllPreField: RST_PLL_PRE};
    end else begin
      if (wrDiv) begin
        div_ff.recoverOnInt <= regWdata[RECOVER_BIT];
        div_ff.reduceField  <= regWdata[REDUCE_LSB +: 3];
        div_ff.frcPostField <= regWdata[FRC_POST_LSB +: 3];
        div_ff.pllPreField  <= regWdata[PLL_PRE_LSB +: 5];
        if (regWdata[PLL_POST_LSB +: 2] != POST_RESERVED) begin
          div_ff.pllPostField <= regWdata[PLL_POST_LSB +: 2]; // reserved code kept out
        end
      end
      // interrupt recovery wins over a write in the same cycle
      if (interruptEvent && div_ff.recoverOnInt) begin
        div_ff.reduceEnable <= 1'b0;
      end else if (wrDiv) begin
        div_ff.reduceEnable <= regWdata[REDUCE_EN_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pllFb_ff <= RST_PLL_FB;
    end else if (wrFb) begin
      pllFb_ff <= regWdata[8:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        ADDR_OSC_CONTROL: begin
          rdata_ff <= 16'h0000;
          rdata_ff[CUR_SRC_LSB +: 3] <= curSrc_ff;
          rdata_ff[NEW_SRC_LSB +: 3] <= newSrc_ff;
          rdata_ff[SRC_LOCK_BIT]     <= srcLock_ff;
          rdata_ff[PIN_LOCK_BIT]     <= pinLock_ff;
          rdata_ff[PLL_LOCK_BIT]     <= pllLockStat_ff;
          rdata_ff[CLK_FAIL_BIT]     <= clkFail_ff;
          rdata_ff[SEC_OSC_BIT]      <= secOsc_ff;
          rdata_ff[SWITCH_BIT]       <= switchReq_ff;
        end
        ADDR_CLK_DIVISOR: begin
          // bit 5 is unimplemented, so the struct does not map straight onto the word
          rdata_ff <= {div_ff.recoverOnInt, div_ff.reduceField, div_ff.reduceEnable,
                       div_ff.frcPostField, div_ff.pllPostField, 1'b0,
                       div_ff.pllPreField};
        end
        ADDR_PLL_FEEDBACK: rdata_ff <= {7'h00, pllFb_ff};
        default:           rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end
  assign regRdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // derived clock configuration
  assign pinSelectWriteOk = pinSelectWrite && !pinLock_ff;
  assign secondaryOscOn   = secOsc_ff;
  assign activeSource     = curSrc_ff;
  // primary mode only matters for primary selections
  assign primaryMode = (curSrc_ff == SRC_PRIMARY || curSrc_ff == SRC_PRI_PLL) ?
                       primaryModeConfig : PRI_EXTERNAL;
  assign usesPll = src_has_pll(curSrc_ff);
  // factors for the analogue loop: Fout = Fin*M/(N1*N2)
  assign pllCfg.prescale   = {1'b0, div_ff.pllPreField} + FACTOR_OFFSET[5:0];
  assign pllCfg.multiplier = {1'b0, pllFb_ff} + {1'b0, FACTOR_OFFSET};
  assign pllCfg.postscale  = (div_ff.pllPostField == 2'h3) ? 4'h8 :
                             (div_ff.pllPostField == 2'h1) ? 4'h4 : 4'h2;
  // 7 selects 256, not 128
  assign frcDivide  = (div_ff.frcPostField == 3'h7) ? 9'h100 :
                      {1'b0, pow2(div_ff.frcPostField)};
  assign dozeDivide = div_ff.reduceEnable ? pow2(div_ff.reduceField) : 8'h01;
  assign instrClkDiv2 = 1'b1; // instruction clock is system clock over two

  scs_clock_mux u_mux (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .srcClocks (srcClocks),
    .selCode   (curSrc_ff),
    .initCode  (initialSourceConfig),
    .clockOut  (systemClock)
  );

  ////////////////////////////////////////////////////////////////////////////
  chk_switch_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (swState_ff == SW_COUNT && newEdge && waitCnt_ff == SWITCH_WAIT - 4'h1) |=>
      (!switchReq_ff && curSrc_ff == $past(newSrc_ff)))
    else $error("switch did not complete");
  chk_pin_lock_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pinLock_ff |-> !pinSelectWriteOk)
    else $error("pin select write passed while locked");
  chk_recover_int: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (interruptEvent && div_ff.recoverOnInt) |=> (dozeDivide == 8'h01))
    else $error("interrupt did not restore ratio");
  chk_fail_sticks: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clockFailDetect |=> clkFail_ff)
    else $error("clock fail lost");
  chk_locked_noswitch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (switchMonitorConfig == FCK_SWITCH_ONLY && srcLock_ff && !switchReq_ff)
      |=> !switchReq_ff)
    else $error("switch request while source locked");
  chk_pre_factor: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pllCfg.prescale == {1'b0, div_ff.pllPreField} + 6'h02)
    else $error("prescale factor wrong");
  chk_post_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n)
    div_ff.pllPostField != POST_RESERVED)
    else $error("reserved postscale stored");
  chk_doze_ratio: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !div_ff.reduceEnable |-> dozeDivide == 8'h01)
    else $error("ratio not forced");
  chk_redundant_abort: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (primed_ff && swState_ff == SW_IDLE && switchReq_ff && newSrc_ff == curSrc_ff)
      |=> !switchReq_ff)
    else $error("redundant switch not aborted");
  chk_start_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (swState_ff == SW_IDLE && switchReq_ff && newSrc_ff != curSrc_ff && !clockFailDetect)
      |=> (!clkFail_ff && !pllLockStat_ff))
    else $error("status not cleared at switch start");
  chk_new_source: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (strapTaken_ff && wrCtrlHi) |=> newSrc_ff == $past(regWdata[NEW_SRC_LSB +: 3]))
    else $error("new source write lost");
  chk_low_refused: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (regWrite && regAddr == ADDR_OSC_CONTROL && !unlockLow) |=> $stable(pinLock_ff))
    else $error("unqualified low byte write took effect");
  chk_ready_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (swState_ff == SW_WAIT_READY && src_has_pll(newSrc_ff) && !pllLocked)
      |=> swState_ff == SW_WAIT_READY)
    else $error("switch left wait before lock");
  chk_prescale_top: assert property (@(posedge sys_clk) disable iff (!reset_n)
    div_ff.pllPreField == 5'h1f |-> pllCfg.prescale == 6'h21)
    else $error("prescale 33 lost");
endmodule

// ===== tb/scs_osc_model.sv
// far side: free-running sources, start-up flags and a pll that locks
// only after it has been asked for, never instantly
module scs_osc_model (
  input  wire logic       sys_clk,     // system clock
  input  wire logic [2:0] selCode,     // source being switched to
  input  wire logic       pllRequest,  // that source runs via the pll
  output logic [7:0]      srcClocks,   // raw source clocks
  output logic [7:0]      srcReady,    // start-up done per source
  output logic            pllLocked,   // pll lock status
  output logic            newSrcClock  // clock of the source being switched to
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] clkReg  = 8'h00;
  logic [7:0] rdyReg  = 8'h00;
  logic [5:0] lockCnt = 6'h00;
  ////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < 8; i++) begin : g_src
    // periods 12..40 ns, all slower than sys_clk so every edge is seen
    always #(6 + 2 * i) clkReg[i] = ~clkReg[i];
    // later codes start slower, though each is ready before the test asks to switch to it
    initial #(100 * (i + 1)) rdyReg[i] = 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (!pllRequest)
      lockCnt <= 6'h00;
    else if (lockCnt != 6'h3f)
      lockCnt <= lockCnt + 6'h01;
  end
  assign srcClocks   = clkReg;
  assign srcReady    = rdyReg;
  assign pllLocked   = (lockCnt == 6'h3f);
  assign newSrcClock = clkReg[selCode];
endmodule

// ===== tb/test_scs_clock_control.sv
module test_scs_clock_control;
  timeunit 1ns;
  timeprecision 100ps;
  import scs_pkg::*;
  logic            sys_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [1:0]      regAddr = 2'h0;
  logic [15:0]     regWdata = 16'h0000;
  logic            regWrite = 1'b0, regRead = 1'b0;
  logic            unlockHigh = 1'b0, unlockLow = 1'b0;
  logic            clockFailDetect = 1'b0, interruptEvent = 1'b0;
  logic            pinSelectWrite = 1'b0, pllRequest = 1'b0;
  logic [2:0]      selCode = 3'h7;
  logic [15:0]     regRdata;
  logic [7:0]      srcClocks, srcReady, dozeDivide;
  logic            pllLocked, newSrcClock, pinSelectWriteOk, secondaryOscOn;
  logic            usesPll, instrClkDiv2, systemClock;
  logic [2:0]      activeSource;
  logic [1:0]      primaryMode;
  logic [8:0]      frcDivide;
  scs_pll_cfg_type pllCfg;
  int              mismatches = 0, testsRun = 0, cycles = 0;
  logic [15:0]     v;
  always #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  scs_clock_control dut (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .initialSourceConfig(3'h7), .primaryModeConfig(PRI_HS_CRYSTAL),
    .switchMonitorConfig(FCK_SWITCH_ONLY), .unlockHigh(unlockHigh), .unlockLow(unlockLow),
    .srcClocks(srcClocks), .srcReady(srcReady), .pllLocked(pllLocked),
    .clockFailDetect(clockFailDetect), .interruptEvent(interruptEvent),
    .newSrcClock(newSrcClock), .pinSelectWrite(pinSelectWrite),
    .pinSelectWriteOk(pinSelectWriteOk), .secondaryOscOn(secondaryOscOn),
    .activeSource(activeSource), .primaryMode(primaryMode), .usesPll(usesPll),
    .pllCfg(pllCfg), .frcDivide(frcDivide), .dozeDivide(dozeDivide),
    .instrClkDiv2(instrClkDiv2), .systemClock(systemClock));
  scs_osc_model osc (.sys_clk(sys_clk), .selCode(selCode), .pllRequest(pllRequest),
    .srcClocks(srcClocks), .srcReady(srcReady), .pllLocked(pllLocked),
    .newSrcClock(newSrcClock));
  ////////////////////////////////////////////////////////////////
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // trailing #1 lets the write land before callers look at outputs
  task automatic wr(input logic [1:0] a, input logic [15:0] d, input logic hi, input logic lo);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    unlockHigh <= hi;
    unlockLow <= lo;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    unlockHigh <= 1'b0;
    unlockLow <= 1'b0;
    #1;
  endtask
  task automatic rdChk(input logic [1:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    v = regRdata;
    check(v, exp);
  endtask
  task automatic sw(input logic [2:0] src, input logic [7:0] low);
    int n;
    @(posedge sys_clk);
    selCode <= src;
    pllRequest <= (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
    wr(ADDR_OSC_CONTROL, {5'h00, src, 8'h00}, 1'b1, 1'b0);
    wr(ADDR_OSC_CONTROL, {8'h00, low | 8'h01}, 1'b0, 1'b1);
    n = 0;
    while (activeSource !== src && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    check(activeSource, src);
    check(n * 4 >= 9 * (12 + 4 * src), 1'b1);
    repeat (2) @(posedge sys_clk);
    rdChk(ADDR_OSC_CONTROL,
          {1'b0, src, 1'b0, src, low[7:6], pllRequest, 3'h0, low[1], 1'b0});
    repeat (12) @(posedge sys_clk);
    #1;
    check(systemClock, srcClocks[src]);
    $display("done: switch to %0d", src);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("MISMATCH at %0t: run did not finish", $time);
      stopTest();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdChk(ADDR_OSC_CONTROL, 16'h7700);
    rdChk(ADDR_CLK_DIVISOR, 16'h3040);
    rdChk(ADDR_PLL_FEEDBACK, 16'h0030);
    rdChk(2'h3, 16'h0000);
    check(pllCfg, {6'h02, 10'h032, 4'h4});
    check(dozeDivide, 8'h01);
    check(instrClkDiv2, 1'b1);
    $display("done: reset values");
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CLK_DIVISOR, {1'b0, i[2:0], 1'b1, i[2:0], 8'h40}, 1'b0, 1'b0);
      check(frcDivide, (i == 7) ? 9'h100 : 9'h001 << i);
      check(dozeDivide, 8'h01 << i);
    end
    wr(ADDR_CLK_DIVISOR, 16'h7040, 1'b0, 1'b0);
    check(dozeDivide, 8'h01);
    wr(ADDR_CLK_DIVISOR, 16'ha840, 1'b0, 1'b0);
    check(dozeDivide, 8'h04);
    @(posedge sys_clk);
    interruptEvent <= 1'b1;
    @(posedge sys_clk);
    interruptEvent <= 1'b0;
    rdChk(ADDR_CLK_DIVISOR, 16'ha040);
    check(dozeDivide, 8'h01);
    $display("done: divisor fields");
    // 10 MHz in, N1 2, M 32, N2 2: vco 5 MHz in, 160 MHz out, 80 MHz pll out
    wr(ADDR_PLL_FEEDBACK, 16'h01ff, 1'b0, 1'b0);
    check(pllCfg.multiplier, 10'h201);
    wr(ADDR_CLK_DIVISOR, 16'h00c0, 1'b0, 1'b0);
    check(pllCfg.postscale, 4'h8);
    wr(ADDR_CLK_DIVISOR, 16'h009f, 1'b0, 1'b0);
    check(pllCfg, {6'h21, 10'h201, 4'h8});
    wr(ADDR_PLL_FEEDBACK, 16'h001e, 1'b0, 1'b0);
    wr(ADDR_CLK_DIVISOR, 16'h0000, 1'b0, 1'b0);
    check(pllCfg, {6'h02, 10'h020, 4'h2});
    $display("done: pll factors");
    wr(ADDR_OSC_CONTROL, 16'h0000, 1'b0, 1'b0);
    rdChk(ADDR_OSC_CONTROL, 16'h7700);
    sw(SRC_FRC, 8'h00);
    check(usesPll, 1'b0);
    sw(SRC_FRC_PLL, 8'h00);
    check(usesPll, 1'b1);
    sw(SRC_FRC, 8'h00);
    sw(SRC_PRIMARY, 8'h00);
    check(primaryMode, PRI_HS_CRYSTAL);
    sw(SRC_SECONDARY, 8'h02);
    check(secondaryOscOn, 1'b1);
    @(posedge sys_clk);
    pinSelectWrite <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(pinSelectWriteOk, 1'b1);
    wr(ADDR_OSC_CONTROL, 16'h0040, 1'b0, 1'b1);
    check(pinSelectWriteOk, 1'b0);
    check(secondaryOscOn, 1'b0);
    @(posedge sys_clk);
    clockFailDetect <= 1'b1;
    @(posedge sys_clk);
    clockFailDetect <= 1'b0;
    rdChk(ADDR_OSC_CONTROL, 16'h4448);
    wr(ADDR_OSC_CONTROL, 16'h0040, 1'b0, 1'b1);
    rdChk(ADDR_OSC_CONTROL, 16'h4440);
    $display("done: pin lock and clock fail");
    wr(ADDR_OSC_CONTROL, 16'h00c0, 1'b0, 1'b1);
    selCode <= SRC_LOW_POWER_INTERNAL_RC;
    wr(ADDR_OSC_CONTROL, 16'h0500, 1'b1, 1'b0);
    wr(ADDR_OSC_CONTROL, 16'h00c1, 1'b0, 1'b1);
    repeat (400) @(posedge sys_clk);
    check(activeSource, SRC_SECONDARY);
    wr(ADDR_OSC_CONTROL, 16'h0040, 1'b0, 1'b1);
    sw(SRC_LOW_POWER_INTERNAL_RC, 8'h40);
    wr(ADDR_OSC_CONTROL, 16'h0041, 1'b0, 1'b1);
    rdChk(ADDR_OSC_CONTROL, 16'h5540);
    $display("done: source lock");
    stopTest();
  end
endmodule
